// >>> pkg/hfa_map.svh
/*
  Timing counts and pin field widths for the half-flash converter
  host controller. Assumes a 20 MHz system clock.
*/
`ifndef HFA_MAP_SVH
`define HFA_MAP_SVH

`define HFA_CLK_NS        50
`define HFA_RD_MIN_NS     60
`define HFA_RD_MAX_NS     600
`define HFA_RD_CYC        (((`HFA_RD_MIN_NS) + (`HFA_CLK_NS) - 1) / (`HFA_CLK_NS))
`define HFA_GAP_NS        2500
`define HFA_GAP_CYC       (((`HFA_GAP_NS) + (`HFA_CLK_NS) - 1) / (`HFA_CLK_NS))
`define HFA_CONV_MAX_NS   2400
`define HFA_TIMEOUT_NS    5000
`define HFA_TIMEOUT_CYC   ((`HFA_TIMEOUT_NS) / (`HFA_CLK_NS))
`define HFA_SETUP_CYC     1
`define HFA_CNT_W         8
`define HFA_CH_W          3
`define HFA_DATA_W        8

`endif

// >>> pkg/hfa_pkg.sv
/*
  Types for the half-flash converter host controller.
  Assumes hfa_map.svh is on the include path.
*/
`include "hfa_map.svh"
package hfa_pkg;

  typedef enum logic [5:0] {
    HFA_IDLE   = 6'b00_0001,
    HFA_SETUP  = 6'b00_0010,
    HFA_STROBE = 6'b00_0100,
    HFA_WAIT   = 6'b00_1000,
    HFA_HOLD   = 6'b01_0000,
    HFA_GAP    = 6'b10_0000
  } hfa_state_t;

  typedef struct packed {
    logic                    mode1;
    logic [`HFA_CH_W-1:0]    channel;
  } hfa_req_t;

  typedef struct packed {
    logic                    timeout;
    logic                    stale;
    logic [`HFA_DATA_W-1:0]  data;
  } hfa_rsp_t;

endpackage

// >>> core/hfa_timer.sv
/*
  Down-counter used for strobe width, gap and timeout.
  Assumes load and run never coincide with reset release glitches.
*/
`timescale 1ns/100ps
module hfa_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // Status
  output logic              done
);

  logic [W-1:0] count;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0) && !load;

endmodule // hfa_timer

// >>> core/hfa_host.sv
/*
  Host side controller of a half-flash 8-bit multi-channel converter.
  Drives select, read strobe and channel address; samples result bus,
  done flag and the open-drain wait request. Pins are taken as
  synchronous to clk_sys; the board resolves the pulled-up ready wire.
*/
`timescale 1ns/100ps
`include "hfa_map.svh"
module hfa_host #(
  parameter int CH_W    = `HFA_CH_W,
  parameter int DATA_W  = `HFA_DATA_W
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // User request
  input  wire logic               req_valid,
  input  wire hfa_pkg::hfa_req_t  req,
  output logic                    req_ready,
  // User answer
  output logic                    rsp_valid,
  output hfa_pkg::hfa_rsp_t       rsp,
  // Converter pins
  output logic                    sel_n,
  output logic                    rd_n,
  output logic [CH_W-1:0]         chan_sel,
  input  wire logic [DATA_W-1:0]  result_bus,
  input  wire logic               done_n,
  input  wire logic               wait_n
);

  hfa_pkg::hfa_state_t state;
  hfa_pkg::hfa_state_t next_state;
  logic                mode1;
  logic                primed;
  logic                tmr_load;
  logic [`HFA_CNT_W-1:0] tmr_value;
  logic                tmr_done;

  hfa_timer #(.W(`HFA_CNT_W)) u_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .load    (tmr_load),
    .value   (tmr_value),
    .done    (tmr_done)
  );

  // Mode 0 waits on done or ready; timeout guards a dead part
  logic conv_done;
  assign conv_done = !done_n || wait_n;

  always_comb begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_value  = '0;
    case (state)
      hfa_pkg::HFA_IDLE: begin
        if (req_valid) begin
          next_state = hfa_pkg::HFA_SETUP;
        end
      end
      hfa_pkg::HFA_SETUP: begin
        // Address stable before the strobe edge
        next_state = hfa_pkg::HFA_STROBE;
        tmr_load   = 1'b1;
        tmr_value  = mode1 ? `HFA_CNT_W'(`HFA_RD_CYC)
                           : `HFA_CNT_W'(`HFA_TIMEOUT_CYC);
      end
      hfa_pkg::HFA_STROBE: begin
        if (mode1 && tmr_done) begin
          next_state = hfa_pkg::HFA_HOLD;
        end else if (!mode1) begin
          next_state = hfa_pkg::HFA_WAIT;
        end
      end
      hfa_pkg::HFA_WAIT: begin
        if (conv_done || tmr_done) begin
          next_state = hfa_pkg::HFA_HOLD;
        end
      end
      hfa_pkg::HFA_HOLD: begin
        next_state = hfa_pkg::HFA_GAP;
        tmr_load   = 1'b1;
        tmr_value  = `HFA_CNT_W'(`HFA_GAP_CYC);
      end
      hfa_pkg::HFA_GAP: begin
        if (tmr_done) begin
          next_state = hfa_pkg::HFA_IDLE;
        end
      end
      default: next_state = hfa_pkg::HFA_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= hfa_pkg::HFA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request capture; channel code is plain binary
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode1    <= 1'b0;
      chan_sel <= '0;
    end else if (state == hfa_pkg::HFA_IDLE && req_valid) begin
      mode1    <= req.mode1;
      chan_sel <= req.channel;
    end
  end

  // Select and strobe fall together, rise together
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sel_n <= 1'b1;
      rd_n  <= 1'b1;
    end else begin
      sel_n <= !(next_state == hfa_pkg::HFA_STROBE ||
                 next_state == hfa_pkg::HFA_WAIT);
      rd_n  <= !(next_state == hfa_pkg::HFA_STROBE ||
                 next_state == hfa_pkg::HFA_WAIT);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (next_state == hfa_pkg::HFA_IDLE);
    end
  end

  // Mode 1 first read after a mode 0 read or reset returns stale data
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      primed <= 1'b0;
    end else if (state == hfa_pkg::HFA_HOLD) begin
      primed <= mode1;
    end
  end

  // Bus floats once strobe rises, so take it on the last low edge
  logic [DATA_W-1:0] bus_q;
  logic              late_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bus_q  <= '0;
      late_q <= 1'b0;
    end else if (next_state == hfa_pkg::HFA_HOLD) begin
      bus_q  <= result_bus;
      late_q <= !mode1 && !conv_done;
    end
  end

  // Answer one cycle after strobe release, bit 7 is MSB
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == hfa_pkg::HFA_HOLD) begin
        rsp_valid    <= 1'b1;
        rsp.data     <= bus_q;
        rsp.stale    <= mode1 && !primed;
        rsp.timeout  <= late_q;
      end
    end
  end

  // Strobe width count in mode 1
  logic [`HFA_CNT_W-1:0] low_cnt;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt <= '0;
    end else if (rd_n) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // Cycles since last strobe rise
  logic [`HFA_CNT_W-1:0] gap_cnt;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt <= '1;
    end else if (!rd_n) begin
      gap_cnt <= '0;
    end else if (gap_cnt != '1) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  property p_sel_rd_together;
    @(posedge clk_sys) disable iff (sys_rst)
      sel_n == rd_n;
  endproperty
  a_sel_rd_together: assert property (p_sel_rd_together)
    else $error("select and strobe differ");

  property p_rd_width;
    @(posedge clk_sys) disable iff (sys_rst)
      ($rose(rd_n) && mode1) |-> (low_cnt >= 8'd2 && low_cnt <= 8'd12);
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("mode 1 strobe width out of range");

  property p_gap;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(rd_n) |-> $past(gap_cnt) >= 8'd49;
  endproperty
  a_gap: assert property (p_gap)
    else $error("reads closer than 2.5 us");

  property p_addr_stable;
    @(posedge clk_sys) disable iff (sys_rst)
      !rd_n |-> $stable(chan_sel);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("channel changed during read");

  property p_mode0_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      (state == hfa_pkg::HFA_WAIT && !conv_done && !tmr_done) |=> !rd_n;
  endproperty
  a_mode0_hold: assert property (p_mode0_hold)
    else $error("mode 0 strobe released early");

  property p_rsp_after_read;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(rd_n) |-> ##1 rsp_valid;
  endproperty
  a_rsp_after_read: assert property (p_rsp_after_read)
    else $error("no answer after read");

  property p_sel_held;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(sel_n) |-> !sel_n [*2];
  endproperty
  a_sel_held: assert property (p_sel_held)
    else $error("select not held");

  property p_mode0_bound;
    @(posedge clk_sys) disable iff (sys_rst)
      ($fell(rd_n) && !mode1) |-> ##[1:102] rd_n;
  endproperty
  a_mode0_bound: assert property (p_mode0_bound)
    else $error("mode 0 read never ended");

endmodule // hfa_host

// >>> tb/hfa_dev_model.sv
/*
  Behavioural model of the half-flash converter seen from its pins.
  Assumes the host drives select, strobe and address on clk_sys edges.
*/
`timescale 1ns/100ps
module hfa_dev_model (
  // Clock
  input  wire logic       clk_sys,
  // Host pins
  input  wire logic       sel_n,
  input  wire logic       rd_n,
  input  wire logic [2:0] chan_sel,
  // Analog stand-in and fault control
  input  wire logic [7:0] level [8],
  input  wire logic       stall,
  // Device outputs
  output logic [7:0]      result_bus,
  output logic            done_n,
  output logic            wait_n
);
  localparam int UP = 20;
  localparam int LO = 12;
  logic       act, act_d, busy, valid, drv;
  logic [7:0] latch, last;
  logic [2:0] ch;
  int         cnt;
  initial begin
    {act_d, busy, valid, ch, latch, last, cnt} = '0;
    done_n = 1'b1;
  end
  assign act = !sel_n && !rd_n;
  // Early in a conversion the old result still shows
  assign drv = act && valid && (!busy || cnt < UP);
  assign result_bus = drv ? latch : ~last;
  assign wait_n = sel_n || !(busy || (act && !act_d));
  always @(posedge clk_sys) begin
    act_d <= act;
    last  <= result_bus;
    if (act && !act_d) begin
      ch     <= chan_sel;
      busy   <= 1'b1;
      cnt    <= 0;
      done_n <= 1'b1;
    end else if (busy && !stall) begin
      cnt <= cnt + 1;
      if (cnt == UP - 1)
        latch[7:4] <= level[ch][7:4];
      if (cnt == UP + LO - 1) begin
        latch[3:0] <= level[ch][3:0];
        busy       <= 1'b0;
        valid      <= 1'b1;
        done_n     <= 1'b0;
      end
    end
    if (!act && act_d)
      done_n <= 1'b1;
  end
endmodule // hfa_dev_model

// >>> tb/tb_top.sv
/*
  Self-checking bench of the converter host against the device model.
  Assumes hfa_map.svh on the include path and a 20 MHz clock.
*/
`timescale 1ns/100ps
`define CHK(nm, e, s) begin comparisons++; if ((e) !== (s)) begin \
  n_mismatch++; $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module tb_top;
  logic              clk_sys = 0, sys_rst = 1, req_valid = 0, stall = 0;
  hfa_pkg::hfa_req_t req = '0;
  hfa_pkg::hfa_rsp_t rsp;
  logic              req_ready, rsp_valid, sel_n, rd_n, done_n, wait_n;
  logic [2:0]        chan_sel;
  logic [7:0]        result_bus;
  logic [7:0]        level [8];
  int                n_mismatch = 0, comparisons = 0, prev = -1, prev_m1 = 0;
  hfa_host hfa_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .sel_n(sel_n), .rd_n(rd_n),
    .chan_sel(chan_sel), .result_bus(result_bus), .done_n(done_n),
    .wait_n(wait_n));
  hfa_dev_model hfa_dev_model_i (.clk_sys(clk_sys), .sel_n(sel_n),
    .rd_n(rd_n), .chan_sel(chan_sel), .level(level), .stall(stall),
    .result_bus(result_bus), .done_n(done_n), .wait_n(wait_n));
  initial forever #25 clk_sys = ~clk_sys;
  task automatic results();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One read; unused channels get the inverse so a wrong pick shows
  task automatic xfer(input logic m1, input logic [2:0] c, input bit to);
    int         n, lo, w;
    logic [7:0] v;
    n = 0; lo = 0; w = 0; v = 8'($urandom);
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) level[i] <= (i == c) ? v : ~v;
    req_valid <= 1'b1;
    req <= '{mode1: m1, channel: c};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (sel_n === 1'b0) lo++;
    end
    if (n >= 200) begin n_mismatch++; results(); end
    `CHK("chan_sel", c, chan_sel)
    `CHK("timeout", to, rsp.timeout)
    if (to) return;
    if (m1) begin
      `CHK("latency", 5, n)
      `CHK("width", 1'b1, lo >= 2 && lo <= 12)
      `CHK("stale", prev_m1 == 0, rsp.stale)
      if (prev >= 0) `CHK("data1", prev[7:0], rsp.data)
    end else begin
      `CHK("conv_time", 1'b1, n <= 48)
      `CHK("data0", v, rsp.data)
    end
    prev = v;
    prev_m1 = m1;
    while (req_ready !== 1'b1 && w < 200) begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    `CHK("gap", 1'b1, w >= 48 && w < 200)
  endtask
  initial begin
    for (int i = 0; i < 8; i++) level[i] = 8'h00;
    void'($urandom(62));
    repeat (16) @(posedge clk_sys);
    `CHK("sel_rst", 1'b1, sel_n)
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("ready", 1'b1, req_ready)
    // Mode mix gives stale and fresh pipelined answers, and mode 1 reads on every channel
    for (int i = 0; i < 18; i++) xfer(i % 3 != 0, 3'(i), 0);
    // Converter that never finishes must end in a timeout answer
    stall <= 1'b1;
    xfer(1'b0, 3'd5, 1);
    results();
  end
endmodule // tb_top
